// File: include/load_step_defs.vh
// load_step_defs.vh: offsets, field positions, reset values and timing counts
// assumes a 100 MHz mclk and classic wishbone word addressing (byte offsets)
`ifndef LOAD_STEP_DEFS_VH
`define LOAD_STEP_DEFS_VH

`define LS_CLK_MHZ         100
`define LS_STEPS           5
`define LS_STEP_W          3
`define LS_KW_W            16
`define LS_DLY_W           16

// register byte offsets
`define LS_REG_CTRL        8'h00
`define LS_REG_DUM_TRIP    8'h04
`define LS_REG_DUM_RET     8'h08
`define LS_REG_DUM_DLY     8'h0C
`define LS_REG_SHD_TRIP    8'h10
`define LS_REG_SHD_RET     8'h14
`define LS_REG_SHD_DLY     8'h18
`define LS_REG_STATUS      8'h1C
`define LS_REG_KW          8'h20

// control field positions
`define LS_CTRL_DUM_EN     0
`define LS_CTRL_SHD_EN     1
`define LS_CTRL_DUM_CNT_LO 4
`define LS_CTRL_SHD_CNT_LO 8
`define LS_CTRL_SHD_ST_LO  12

// reset values
`define LS_CTRL_RST        32'h0000_0000
`define LS_KW_RST          16'h0000
`define LS_DLY_RST         16'h000A

// delay tick: 1 ms in microseconds, cycles derived from the clock rate
`define LS_TICK_US         1000
`define LS_TICK_CYC        (`LS_TICK_US * `LS_CLK_MHZ)
`define LS_TICK_W          17

`endif

// File: src/step_delay.v
// step_delay.v: qualifying delay timer counting ticks while a condition holds
// assumes tick is a one-cycle enable pulse on mclk
`timescale 1ns/1ns
`include "load_step_defs.vh"

module step_delay (
  input  wire                 mclk,   // system clock
  input  wire                 rst,    // sync reset, active high
  input  wire                 run,    // threshold condition present
  input  wire                 tick,   // delay time base pulse
  input  wire [`LS_DLY_W-1:0] limit,  // delay length in ticks
  output reg                  expire  // one-cycle pulse on qualification
);

  reg [`LS_DLY_W-1:0] cnt_r;

  // condition dropping clears the count so timing restarts afresh
  always @(posedge mclk) begin
    if (rst || !run) begin
      cnt_r  <= {`LS_DLY_W{1'b0}};
      expire <= 1'b0;
    end else if (expire) begin
      cnt_r  <= {`LS_DLY_W{1'b0}};
      expire <= 1'b0;
    end else if (tick) begin
      if (cnt_r + 16'h0001 >= limit) begin
        expire <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

endmodule

// File: src/load_step_controller.v
// load_step_controller.v: dummy load and load shedding step sequencer
// assumes kw, gen_running, about_to_load, on_load and stopping come from pins
// and are synchronised here; registers reached over classic wishbone
//
// Contract
// - Dummy stepping has up to five steps, runs only when enabled, and is bounded by the count.
// - At start all dummy outputs are off and dummy monitoring begins only once on load.
// - Load below the dummy trip for the full delay energises the next dummy step.
// - Load above the dummy return for the full delay drops the highest dummy step.
// - On stopping all dummy and shedding outputs turn off together with the open command.
// - Shedding has up to five steps and runs only when enabled.
// - Just before taking load the at-start number of shedding outputs are energised.
// - Load above the shedding trip for the full delay energises the next shedding step.
// - Load below the shedding return for the full delay drops the highest shedding step.
`timescale 1ns/1ns
`include "load_step_defs.vh"

// tick period is a parameter so a bench can shorten it; the default is 1 ms
module load_step_controller #(
  parameter TICK_CYC = `LS_TICK_CYC // cycles per delay tick
) (
  input  wire                  mclk,          // 100 MHz clock
  input  wire                  rst,           // sync reset, active high
  input  wire [31:0]           wb_adr_i,      // wishbone address
  input  wire [31:0]           wb_dat_i,      // wishbone write data
  input  wire [3:0]            wb_sel_i,      // wishbone byte selects
  input  wire                  wb_we_i,       // wishbone write enable
  input  wire                  wb_cyc_i,      // wishbone cycle
  input  wire                  wb_stb_i,      // wishbone strobe
  output reg  [31:0]           wb_dat_o,      // wishbone read data
  output reg                   wb_ack_o,      // wishbone acknowledge
  output reg                   wb_err_o,      // unmapped address answer
  input  wire [`LS_KW_W-1:0]   kw_in,         // measured generator kW
  input  wire                  gen_running,   // generator started
  input  wire                  about_to_load, // load transfer imminent
  input  wire                  on_load,       // generator load switch closed
  input  wire                  stopping,      // stopping sequence entered
  output reg                   load_open,     // load switch open command
  output reg  [`LS_STEPS-1:0]  dummy_out,     // dummy step relays
  output reg  [`LS_STEPS-1:0]  shed_out       // shedding step relays
);

  // two-flop synchronisers for pin inputs; first stage read only by second
  reg [`LS_KW_W-1:0] kw_m_r, kw_r;
  reg [3:0]          st_m_r, st_r;
  always @(posedge mclk) begin
    if (rst) begin
      kw_m_r <= `LS_KW_RST;
      kw_r   <= `LS_KW_RST;
      st_m_r <= 4'h0;
      st_r   <= 4'h0;
    end else begin
      kw_m_r <= kw_in;
      kw_r   <= kw_m_r;
      st_m_r <= {stopping, on_load, about_to_load, gen_running};
      st_r   <= st_m_r;
    end
  end
  // kw bus may skew across bits; thresholds are tolerant of one-sample error
  wire run_s   = st_r[0];
  wire pre_s   = st_r[1];
  wire load_s  = st_r[2];
  wire stop_s  = st_r[3];

  // configuration registers
  reg [31:0]          ctrl_r;
  reg [`LS_KW_W-1:0]  dum_trip_r, dum_ret_r, shd_trip_r, shd_ret_r;
  reg [31:0]          dum_dly_r, shd_dly_r;
  wire                dum_en  = ctrl_r[`LS_CTRL_DUM_EN];
  wire                shd_en  = ctrl_r[`LS_CTRL_SHD_EN];
  wire [2:0]          dum_cnt_raw = ctrl_r[`LS_CTRL_DUM_CNT_LO +: 3];
  wire [2:0]          shd_cnt_raw = ctrl_r[`LS_CTRL_SHD_CNT_LO +: 3];
  wire [2:0]          shd_st_raw  = ctrl_r[`LS_CTRL_SHD_ST_LO +: 3];
  // counts above five clamp to five
  wire [2:0] dum_cnt = (dum_cnt_raw > 3'h5) ? 3'h5 : dum_cnt_raw;
  wire [2:0] shd_cnt = (shd_cnt_raw > 3'h5) ? 3'h5 : shd_cnt_raw;
  wire [2:0] shd_st  = (shd_st_raw > shd_cnt) ? shd_cnt : shd_st_raw;

  // wishbone slave: ack one cycle after strobe, dropped the next cycle
  wire       req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire [7:0] adr   = wb_adr_i[7:0];
  wire       hit   = (wb_adr_i[31:6] == 26'h0) && (adr[1:0] == 2'b00) &&
                     (adr <= `LS_REG_KW);
  wire       wr    = req && hit && wb_we_i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // merged write words; thresholds keep only their low half
  wire [31:0] dum_trip_wd = merge({16'h0000, dum_trip_r}, wb_dat_i, wb_sel_i);
  wire [31:0] dum_ret_wd  = merge({16'h0000, dum_ret_r}, wb_dat_i, wb_sel_i);
  wire [31:0] shd_trip_wd = merge({16'h0000, shd_trip_r}, wb_dat_i, wb_sel_i);
  wire [31:0] shd_ret_wd  = merge({16'h0000, shd_ret_r}, wb_dat_i, wb_sel_i);

  // register writes
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_r     <= `LS_CTRL_RST;
      dum_trip_r <= `LS_KW_RST;
      dum_ret_r  <= `LS_KW_RST;
      shd_trip_r <= `LS_KW_RST;
      shd_ret_r  <= `LS_KW_RST;
      dum_dly_r  <= {16'h0000, `LS_DLY_RST};
      shd_dly_r  <= {16'h0000, `LS_DLY_RST};
    end else if (wr) begin
      case (adr)
        `LS_REG_CTRL:     ctrl_r     <= merge(ctrl_r, wb_dat_i, wb_sel_i);
        `LS_REG_DUM_TRIP: dum_trip_r <= dum_trip_wd[15:0];
        `LS_REG_DUM_RET:  dum_ret_r  <= dum_ret_wd[15:0];
        `LS_REG_DUM_DLY:  dum_dly_r  <= merge(dum_dly_r, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
        `LS_REG_SHD_TRIP: shd_trip_r <= shd_trip_wd[15:0];
        `LS_REG_SHD_RET:  shd_ret_r  <= shd_ret_wd[15:0];
        `LS_REG_SHD_DLY:  shd_dly_r  <= merge(shd_dly_r, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
        default:          ctrl_r     <= ctrl_r;
      endcase
    end
  end

  // sequencing state
  localparam ST_IDLE = 2'b00;
  localparam ST_PRE  = 2'b01;
  localparam ST_LOAD = 2'b10;
  localparam ST_STOP = 2'b11;
  reg [1:0] state_r, state_nxt;
  reg [2:0] dum_lvl_r, shd_lvl_r;

  // read mux
  reg [31:0] rd_nxt;
  always @* begin
    case (adr)
      `LS_REG_CTRL:     rd_nxt = ctrl_r;
      `LS_REG_DUM_TRIP: rd_nxt = {16'h0000, dum_trip_r};
      `LS_REG_DUM_RET:  rd_nxt = {16'h0000, dum_ret_r};
      `LS_REG_DUM_DLY:  rd_nxt = dum_dly_r;
      `LS_REG_SHD_TRIP: rd_nxt = {16'h0000, shd_trip_r};
      `LS_REG_SHD_RET:  rd_nxt = {16'h0000, shd_ret_r};
      `LS_REG_SHD_DLY:  rd_nxt = shd_dly_r;
      `LS_REG_STATUS:   rd_nxt = {16'h0000, 2'b00, state_r, 1'b0, shd_lvl_r,
                                  1'b0, dum_lvl_r, 3'b000, load_open};
      `LS_REG_KW:       rd_nxt = {16'h0000, kw_r};
      default:          rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      wb_dat_o <= (req && hit && !wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // delay time base: one pulse per millisecond
  reg [`LS_TICK_W-1:0] div_r;
  reg                  tick_r;
  always @(posedge mclk) begin
    if (rst) begin
      div_r  <= {`LS_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end else if (div_r == TICK_CYC - 1) begin
      div_r  <= {`LS_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  // supervision only while on load and not stopping
  wire active   = (state_r == ST_LOAD);
  wire dum_low  = active && dum_en && (kw_r < dum_trip_r) && (dum_lvl_r < dum_cnt);
  wire dum_high = active && dum_en && (kw_r > dum_ret_r) && (dum_lvl_r != 3'h0);
  wire shd_high = active && shd_en && (kw_r > shd_trip_r) && (shd_lvl_r < shd_cnt);
  wire shd_low  = active && shd_en && (kw_r < shd_ret_r) && (shd_lvl_r != 3'h0);
  wire [3:0] exp_w;
  wire [3:0] run_w = {shd_low, shd_high, dum_high, dum_low};
  wire [`LS_DLY_W-1:0] lim_w [0:3];
  assign lim_w[0] = dum_dly_r[15:0];
  assign lim_w[1] = dum_dly_r[15:0];
  assign lim_w[2] = shd_dly_r[15:0];
  assign lim_w[3] = shd_dly_r[15:0];

  // one qualifying timer per direction; dropping the condition restarts it
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : dly
      step_delay u_dly (
        .mclk   (mclk),
        .rst    (rst),
        .run    (run_w[g]),
        .tick   (tick_r),
        .limit  (lim_w[g]),
        .expire (exp_w[g])
      );
    end
  endgenerate

  // phase of the generator's loading cycle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (pre_s && !stop_s) state_nxt = ST_PRE;
               else if (load_s && !stop_s) state_nxt = ST_LOAD;
      ST_PRE:  if (stop_s) state_nxt = ST_STOP;
               else if (load_s) state_nxt = ST_LOAD;
      ST_LOAD: if (stop_s || !load_s) state_nxt = ST_STOP;
      ST_STOP: if (!stop_s && !load_s && !pre_s) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // step levels and relays; the stop clears everything with the open command
  always @(posedge mclk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      dum_lvl_r <= 3'h0;
      shd_lvl_r <= 3'h0;
      load_open <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == ST_STOP || !run_s) begin
        dum_lvl_r <= 3'h0;
        shd_lvl_r <= 3'h0;
        load_open <= 1'b1;
      end else if (state_r == ST_IDLE && state_nxt == ST_PRE) begin
        shd_lvl_r <= shd_en ? shd_st : 3'h0;
        dum_lvl_r <= 3'h0;
      end else if (state_nxt == ST_LOAD) begin
        load_open <= 1'b0;
        if (!dum_en) dum_lvl_r <= 3'h0;
        else if (exp_w[0]) dum_lvl_r <= dum_lvl_r + 3'h1;
        else if (exp_w[1]) dum_lvl_r <= dum_lvl_r - 3'h1;
        if (!shd_en) shd_lvl_r <= 3'h0;
        else if (exp_w[2]) shd_lvl_r <= shd_lvl_r + 3'h1;
        else if (exp_w[3]) shd_lvl_r <= shd_lvl_r - 3'h1;
      end
    end
  end

  // thermometer decode of levels to relays, cleared in the stop cycle itself
  generate
    for (g = 0; g < `LS_STEPS; g = g + 1) begin : rel
      always @(posedge mclk) begin
        if (rst || state_nxt == ST_STOP || !run_s) begin
          dummy_out[g] <= 1'b0;
          shed_out[g]  <= 1'b0;
        end else begin
          dummy_out[g] <= (g < dum_lvl_r);
          shed_out[g]  <= (g < shd_lvl_r);
        end
      end
    end
  endgenerate

endmodule

// File: dv/load_step_chk.sv
// load_step_chk.sv: port-level assertions for the load step controller
// assumes binding onto load_step_controller, single mclk domain
`timescale 1ns/1ns
`include "load_step_defs.vh"
module load_step_chk (
  input wire                 mclk,      // clock
  input wire                 rst,       // sync reset
  input wire                 wb_cyc_i,  // bus cycle
  input wire                 wb_stb_i,  // bus strobe
  input wire                 wb_ack_o,  // bus ack
  input wire                 wb_err_o,  // bus error
  input wire                 stopping,  // stop pin
  input wire                 load_open, // open command
  input wire [`LS_STEPS-1:0] dummy_out, // dummy relays
  input wire [`LS_STEPS-1:0] shed_out   // shed relays
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // a taken request with no answer pending
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_stop_held;
    stopping [*4];
  endsequence
  a_bus_answer: assert property (s_req |=> (wb_ack_o || wb_err_o))
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_dummy_therm: assert property ((dummy_out & (dummy_out + 5'h01)) == 5'h00)
    else $error("dummy steps not contiguous");
  a_shed_therm: assert property ((shed_out & (shed_out + 5'h01)) == 5'h00)
    else $error("shed steps not contiguous");
  a_dummy_one_step: assert property (!$stable(dummy_out) && dummy_out != 0 |->
    $countones(dummy_out) == $countones($past(dummy_out)) + 1 ||
    $countones(dummy_out) + 1 == $countones($past(dummy_out)))
    else $error("dummy moved more than one step");
  a_shed_one_step: assert property ($past(shed_out) != 0 && shed_out != 0
    && !$stable(shed_out) |-> $countones(shed_out) == $countones($past(shed_out)) + 1 ||
    $countones(shed_out) + 1 == $countones($past(shed_out)))
    else $error("shed moved more than one step");
  a_open_clears: assert property ($rose(load_open) |-> dummy_out == 0 && shed_out == 0)
    else $error("relays left on at open command");
  a_dummy_on_load: assert property (dummy_out != 0 |-> !load_open)
    else $error("dummy step while off load");
  a_stop_opens: assert property (s_stop_held |-> load_open)
    else $error("stop did not open load switch");
endmodule
bind load_step_controller load_step_chk i_load_step_chk (.mclk(mclk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .stopping(stopping), .load_open(load_open), .dummy_out(dummy_out), .shed_out(shed_out));

// File: dv/genset_model.sv
// genset_model.sv: generator power meter reacting to the step relays
// assumes relays act within one mclk; demand is set by the bench
`timescale 1ns/1ns
`include "load_step_defs.vh"
module genset_model (
  input  wire                 mclk,      // clock
  input  wire [`LS_KW_W-1:0]  base_kw,   // site demand
  input  wire [`LS_STEPS-1:0] dummy_out, // dummy relays
  input  wire [`LS_STEPS-1:0] shed_out,  // shed relays
  output reg  [`LS_KW_W-1:0]  kw_in      // metered power
);
  localparam [15:0] DUM_KW = 16'h0064; // load bank per dummy step
  localparam [15:0] SHD_KW = 16'h0032; // feeder per shed step, small to avoid wrap
  initial kw_in = 16'h0000;
  // meter follows demand plus banks minus shed feeders
  always @(posedge mclk) begin
    kw_in <= base_kw + DUM_KW * 16'($countones(dummy_out)) - SHD_KW * 16'($countones(shed_out));
  end
endmodule

// File: dv/tb_load_step_controller.sv
// tb_load_step_controller.sv: directed bench for the step controller
// runs the delay tick at 100 cycles so each delay step costs about 100 cycles
`timescale 1ns/1ns
`include "load_step_defs.vh"
module tb_load_step_controller;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [31:0] wb_adr_i = 32'h0;
  reg  [31:0] wb_dat_i = 32'h0;
  reg  [3:0]  wb_sel_i = 4'hF;
  reg         wb_we_i = 1'b0;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         gen_running = 1'b0;
  reg         about_to_load = 1'b0;
  reg         on_load = 1'b0;
  reg         stopping = 1'b0;
  reg  [15:0] base_kw = 16'h0064;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        wb_err_o;
  wire [15:0] kw_in;
  wire        load_open;
  wire [4:0]  dummy_out;
  wire [4:0]  shed_out;
  integer     num_errors = 0;
  integer     samples_checked = 0;
  reg  [31:0] q;
  reg         e;
  always #5 mclk = ~mclk;
  load_step_controller #(.TICK_CYC(100)) i_load_step_controller (.mclk(mclk), .rst(rst),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .kw_in(kw_in), .gen_running(gen_running), .about_to_load(about_to_load),
    .on_load(on_load), .stopping(stopping), .load_open(load_open),
    .dummy_out(dummy_out), .shed_out(shed_out));
  genset_model i_genset_model (.mclk(mclk), .base_kw(base_kw), .dummy_out(dummy_out),
    .shed_out(shed_out), .kw_in(kw_in));
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle, held until ack or err is seen at an edge
  task bus(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
      do begin
        @(posedge mclk);
        n = n + 1;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
      check({31'h0, n < 20}, 32'h1);
    end
  endtask
  // relays settle to a state; bound covers ten delay ticks
  task wait_out(input [4:0] d, input [4:0] s, input lo);
    integer n;
    begin
      n = 0;
      while (!(dummy_out === d && shed_out === s) && n < 1000) begin
        @(posedge mclk);
        n = n + 1;
      end
      check({21'h0, load_open, dummy_out, shed_out}, {21'h0, lo, d, s});
    end
  endtask
  task t_regs;
    begin
      bus(1'b0, 32'h0, 32'h0); check(q, 32'h0); check({31'h0, e}, 32'h0);
      bus(1'b0, 32'h18, 32'h0); check(q, 32'h0A); check({31'h0, e}, 32'h0);
      bus(1'b0, 32'h24, 32'h0); check({31'h0, e}, 32'h1);
      bus(1'b1, 32'h04, 32'h64); bus(1'b0, 32'h04, 32'h0); check(q, 32'h64);
      // only the low byte lane is written
      wb_sel_i <= 4'h1;
      bus(1'b1, 32'h04, 32'hFFFF_FF32);
      wb_sel_i <= 4'hF;
      bus(1'b0, 32'h04, 32'h0); check(q, 32'h32);
      bus(1'b1, 32'h04, 32'h64);
      // counts dummy 2, shed 3, one shed at start, both schemes on
      bus(1'b1, 32'h0, 32'h1323); bus(1'b1, 32'h08, 32'h1F4); bus(1'b1, 32'h0C, 32'h1);
      bus(1'b1, 32'h10, 32'h3E8); bus(1'b1, 32'h14, 32'h14); bus(1'b1, 32'h18, 32'h1);
      $display("test regs done");
    end
  endtask
  task t_run;
    begin
      @(posedge mclk);
      gen_running <= 1'b1; about_to_load <= 1'b1;
      wait_out(5'h00, 5'h01, 1'b1);
      @(posedge mclk);
      on_load <= 1'b1; about_to_load <= 1'b0;
      wait_out(5'h01, 5'h01, 1'b0);
      $display("test dummy done");
      // longer delays; two short excursions must not add up to one expiry
      bus(1'b1, 32'h0C, 32'h5); bus(1'b1, 32'h18, 32'h5);
      repeat (2) begin
        base_kw <= 16'h07D0;
        repeat (380) @(posedge mclk);
        base_kw <= 16'h0064;
        repeat (300) @(posedge mclk);
      end
      repeat (400) @(posedge mclk);
      check({21'h0, load_open, dummy_out, shed_out}, {21'h0, 1'b0, 5'h01, 5'h01});
      bus(1'b0, 32'h1C, 32'h0); check(q, 32'h0000_2110);
      bus(1'b0, 32'h20, 32'h0); check(q, 32'h0000_0096);
      bus(1'b1, 32'h0C, 32'h1); bus(1'b1, 32'h18, 32'h1);
      $display("test hold done");
      base_kw <= 16'h07D0;
      wait_out(5'h00, 5'h07, 1'b0);
      $display("test shed done");
      stopping <= 1'b1; on_load <= 1'b0;
      wait_out(5'h00, 5'h00, 1'b1);
      $display("test stop done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors = num_errors + 1;
    $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    check({31'h0, load_open}, 32'h1);
    t_regs;
    t_run;
    give_verdict;
  end
endmodule
